// File: core/secl_pkg.sv
// Package of constants for the serial EEPROM configuration loader.
package secl_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [31:0] OFF_EPROM_EXT    = 32'h1ffa0028;
    localparam logic [31:0] OFF_SUBSYS_ID    = 32'h1ffa502c;
    localparam logic [31:0] OFF_LOCAL_WINDOW = 32'h1ffa0100;
    localparam logic [31:0] OFF_LOCAL_BUS    = 32'h1ffa0104;
    localparam logic [31:0] OFF_LOAD_STATUS  = 32'h1ffa0108;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_SUBSYS_ID    = 32'h00000000;
    localparam logic [5:0]  RST_EXT_FIELD    = 6'h00;
    localparam logic [5:0]  RST_BUS_BASE     = 6'h00;
    localparam logic [3:0]  RST_WINDOW_BASE  = 4'h0;
    // ------------------------------------------------------------------
    // Word addresses and configuration word layout
    // ------------------------------------------------------------------
    localparam logic [5:0]  WADDR_ID_LO      = 6'h00;
    localparam logic [5:0]  WADDR_ID_HI      = 6'h01;
    localparam logic [5:0]  WADDR_CONFIG     = 6'h02;
    localparam int          CFG_BUS_LSB      = 10;
    localparam int          CFG_EXT_LSB      = 4;
    localparam int          CFG_WIN_LSB      = 0;
    localparam int          BUS_REG_LSB      = 26;
    localparam int          WIN_REG_LSB      = 16;
    // ------------------------------------------------------------------
    // Serial protocol
    // ------------------------------------------------------------------
    localparam logic [2:0]  OPC_READ         = 3'b110;
    localparam int          CMD_BITS         = 9;
    localparam int          DATA_BITS        = 16;
    // Serial clock of 1 MHz: half period 500 ns.
    localparam int          HALF_PERIOD_NS   = 500;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam int          HALF_CYCLES      = HALF_PERIOD_NS / CLK_PERIOD_NS;
endpackage : secl_pkg

// File: core/secl_sync.sv
// Two-flop synchroniser for an input pin.
`timescale 1ns/1ps
module secl_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Data
    input  wire logic din,
    output logic      dout
);
    logic stage_ff;
    logic dout_ff;
    logic nxt_stage;
    logic nxt_dout;

    always_comb begin
        nxt_stage = din;
        nxt_dout  = stage_ff;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            stage_ff <= 1'b0;
            dout_ff  <= 1'b0;
        end else begin
            stage_ff <= nxt_stage;
            dout_ff  <= nxt_dout;
        end
    end

    assign dout = dout_ff;
endmodule : secl_sync

// File: core/secl_loader.sv
// Serial EEPROM configuration loader with its register port.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module secl_loader
    import secl_pkg::*;
#(
    parameter int HALF = HALF_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    // Serial memory pins
    output logic             mem_select,
    output logic             mem_clock,
    output logic             mem_dout,
    input  wire logic        mem_din,
    // Status
    output logic             load_busy,
    output logic             mem_present
);
    // ------------------------------------------------------------------
    // Pin input
    // ------------------------------------------------------------------
    logic din_sync;
    secl_sync u_sync (
        .clock (clock),
        .reset (reset),
        .din   (mem_din),
        .dout  (din_sync)
    );

    // ------------------------------------------------------------------
    // Serial sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_START, ST_DATA, ST_GAP, ST_DONE} secl_state_t;

    secl_state_t  state_ff, nxt_state;
    logic [15:0]  div_ff, nxt_div;
    logic         phase_ff, nxt_phase;
    logic [4:0]   bit_ff, nxt_bit;
    logic [8:0]   cmd_ff, nxt_cmd;
    logic [15:0]  shift_ff, nxt_shift;
    logic [1:0]   word_ff, nxt_word;
    logic         sel_ff, nxt_sel;
    logic         sck_ff, nxt_sck;
    logic         present_ff, nxt_present;
    logic         absent_ff, nxt_absent;
    logic [31:0]  ident_ff, nxt_ident;
    logic [5:0]   ext_ff, nxt_ext;
    logic [5:0]   bus_ff, nxt_bus;
    logic [3:0]   win_ff, nxt_win;
    logic [31:0]  rdata_ff, nxt_rdata;
    logic         tick;
    logic [5:0]   word_addr;

    assign tick = (div_ff == 16'(HALF - 1));

    always_comb begin
        unique case (word_ff)
            2'd0:    word_addr = WADDR_ID_LO;
            2'd1:    word_addr = WADDR_ID_HI;
            default: word_addr = WADDR_CONFIG;
        endcase
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_div     = tick ? 16'h0000 : div_ff + 16'h0001;
        nxt_phase   = phase_ff;
        nxt_bit     = bit_ff;
        nxt_cmd     = cmd_ff;
        nxt_shift   = shift_ff;
        nxt_word    = word_ff;
        nxt_sel     = sel_ff;
        nxt_sck     = sck_ff;
        nxt_present = present_ff;
        nxt_absent  = absent_ff;
        nxt_ident   = ident_ff;
        nxt_ext     = ext_ff;
        nxt_bus     = bus_ff;
        nxt_win     = win_ff;
        if (tick) begin
            unique case (state_ff)
                ST_IDLE: begin
                    nxt_sel   = 1'b1;
                    nxt_cmd   = {OPC_READ, word_addr};
                    nxt_bit   = 5'(CMD_BITS - 1);
                    nxt_phase = 1'b0;
                    nxt_state = ST_CMD;
                end
                ST_CMD: begin
                    nxt_sck   = ~phase_ff;
                    nxt_phase = ~phase_ff;
                    if (phase_ff) begin
                        nxt_cmd = {cmd_ff[7:0], 1'b0};
                        if (bit_ff == 5'd0) begin
                            nxt_state = ST_START;
                        end else begin
                            nxt_bit = bit_ff - 5'd1;
                        end
                    end
                end
                ST_START: begin
                    // An attached memory drives a zero dummy bit after the address;
                    // a pulled-up floating line means the memory is missing.
                    if (din_sync) begin
                        nxt_absent = 1'b1;
                        nxt_sel    = 1'b0;
                        nxt_state  = ST_DONE;
                    end else begin
                        nxt_bit   = 5'(DATA_BITS - 1);
                        nxt_phase = 1'b0;
                        nxt_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    nxt_sck   = ~phase_ff;
                    nxt_phase = ~phase_ff;
                    if (phase_ff) begin
                        nxt_shift = {shift_ff[14:0], din_sync};
                        if (bit_ff == 5'd0) begin
                            nxt_state = ST_GAP;
                        end else begin
                            nxt_bit = bit_ff - 5'd1;
                        end
                    end
                end
                ST_GAP: begin
                    nxt_sel = 1'b0;
                    nxt_sck = 1'b0;
                    unique case (word_ff)
                        2'd0:    nxt_ident[15:0]  = shift_ff;
                        2'd1:    nxt_ident[31:16] = shift_ff;
                        default: begin
                            nxt_bus = shift_ff[CFG_BUS_LSB +: 6];
                            nxt_ext = shift_ff[CFG_EXT_LSB +: 6];
                            nxt_win = shift_ff[CFG_WIN_LSB +: 4];
                        end
                    endcase
                    if (word_ff == 2'd2) begin
                        nxt_present = 1'b1;
                        nxt_state   = ST_DONE;
                    end else begin
                        nxt_word  = word_ff + 2'd1;
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_DONE;
                end
            endcase
        end
        // Software writes are taken only after loading, so they are never overwritten.
        if (reg_write && state_ff == ST_DONE) begin
            unique case (reg_addr)
                OFF_SUBSYS_ID:    nxt_ident = reg_wdata;
                OFF_EPROM_EXT:    nxt_ext  = reg_wdata[5:0];
                OFF_LOCAL_WINDOW: nxt_win  = reg_wdata[WIN_REG_LSB +: 4];
                OFF_LOCAL_BUS:    nxt_bus  = reg_wdata[BUS_REG_LSB +: 6];
                default:          nxt_ident = ident_ff;
            endcase
        end
        unique case (reg_addr)
            OFF_SUBSYS_ID:    nxt_rdata = ident_ff;
            OFF_EPROM_EXT:    nxt_rdata = {26'h0, ext_ff};
            OFF_LOCAL_WINDOW: nxt_rdata = {12'h0, win_ff, 16'h0};
            OFF_LOCAL_BUS:    nxt_rdata = {bus_ff, 26'h0};
            OFF_LOAD_STATUS:  nxt_rdata = {29'h0, absent_ff, present_ff,
                                           state_ff != ST_DONE};
            default:          nxt_rdata = 32'h00000000;
        endcase
        if (!reg_read) begin
            nxt_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff   <= ST_IDLE;
            div_ff     <= 16'h0000;
            phase_ff   <= 1'b0;
            bit_ff     <= 5'd0;
            cmd_ff     <= 9'h000;
            shift_ff   <= 16'h0000;
            word_ff    <= 2'd0;
            sel_ff     <= 1'b0;
            sck_ff     <= 1'b0;
            present_ff <= 1'b0;
            absent_ff  <= 1'b0;
            ident_ff   <= RST_SUBSYS_ID;
            ext_ff     <= RST_EXT_FIELD;
            bus_ff     <= RST_BUS_BASE;
            win_ff     <= RST_WINDOW_BASE;
            rdata_ff   <= 32'h00000000;
        end else begin
            state_ff   <= nxt_state;
            div_ff     <= nxt_div;
            phase_ff   <= nxt_phase;
            bit_ff     <= nxt_bit;
            cmd_ff     <= nxt_cmd;
            shift_ff   <= nxt_shift;
            word_ff    <= nxt_word;
            sel_ff     <= nxt_sel;
            sck_ff     <= nxt_sck;
            present_ff <= nxt_present;
            absent_ff  <= nxt_absent;
            ident_ff   <= nxt_ident;
            ext_ff     <= nxt_ext;
            bus_ff     <= nxt_bus;
            win_ff     <= nxt_win;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata   = rdata_ff;
    assign mem_select  = sel_ff;
    assign mem_clock   = sck_ff;
    assign mem_dout    = sel_ff & cmd_ff[8];
    assign load_busy   = (state_ff != ST_DONE);
    assign mem_present = present_ff;
endmodule : secl_loader

// File: sim/secl_loader_sva.sv
// Checker of the loader's port behaviour.
`timescale 1ns/1ps
module secl_loader_sva
    import secl_pkg::*;
#(
    parameter int HALF = HALF_CYCLES
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // Serial memory pins
    input wire logic        mem_select,
    input wire logic        mem_clock,
    input wire logic        mem_dout,
    input wire logic        mem_din,
    // Status
    input wire logic        load_busy,
    input wire logic        mem_present
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    logic [15:0] hi_ff;
    logic [15:0] nxt_hi;
    always_comb begin
        nxt_hi = mem_clock ? hi_ff + 16'h1 : 16'h0;
    end
    always_ff @(posedge clock) begin
        hi_ff <= reset ? 16'h0 : nxt_hi;
    end
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_status_read: assert property (reg_read && reg_addr == OFF_LOAD_STATUS |=>
        reg_rdata[1:0] == {$past(mem_present), $past(load_busy)})
        else $error("status read wrong");
    a_no_traffic: assert property (!load_busy |-> !mem_select)
        else $error("memory selected after load");
    a_present_done: assert property (mem_present |-> !load_busy)
        else $error("present while busy");
    a_present_hold: assert property (mem_present |=> mem_present)
        else $error("present flag dropped");
    a_clock_idle: assert property (!mem_select |-> !mem_clock)
        else $error("serial clock outside select");
    a_dout_stable: assert property (mem_clock && $past(mem_clock) |-> $stable(mem_dout))
        else $error("data changed in high half");
    a_half_period: assert property ($fell(mem_clock) |-> hi_ff == 16'(HALF))
        else $error("serial clock high half wrong length");
    a_busy_start: assert property ($past(reset) |-> load_busy && !mem_present)
        else $error("load not started after reset");
    cover property ($rose(mem_present));
    cover property ($fell(load_busy) && !mem_present);
    cover property (reg_read && reg_addr == OFF_SUBSYS_ID);
endmodule : secl_loader_sva

bind secl_loader secl_loader_sva #(.HALF(HALF)) u_secl_loader_sva (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_select(mem_select), .mem_clock(mem_clock), .mem_dout(mem_dout),
    .mem_din(mem_din), .load_busy(load_busy), .mem_present(mem_present)
);

// File: sim/secl_eeprom_model.sv
// Behavioural three-wire serial memory holding three words.
`timescale 1ns/1ps
module secl_eeprom_model #(
    parameter logic [15:0] WORD0 = 16'h0000,
    parameter logic [15:0] WORD1 = 16'h0000,
    parameter logic [15:0] WORD2 = 16'h0000
) (
    // Serial pins
    input  wire logic mem_select,
    input  wire logic mem_clock,
    input  wire logic mem_dout,
    output logic      mem_din,
    // Control and status
    input  wire logic fitted,
    output logic      bad_command
);
    logic [8:0]  cmd = 9'h0;
    logic [15:0] word = 16'h0;
    logic        drv = 1'b1;
    int          edges = 0;
    initial bad_command = 1'b0;
    // A missing or deselected part leaves the line to its pull-up.
    assign mem_din = (fitted && mem_select) ? drv : 1'b1;
    always @(posedge mem_clock or negedge mem_select) begin
        if (!mem_select) begin
            edges = 0;
            drv = 1'b1;
        end else begin
            edges = edges + 1;
            if (edges <= 9) cmd = {cmd[7:0], mem_dout};
            if (edges == 9) begin
                word = (cmd[5:0] == 6'h0) ? WORD0 : (cmd[5:0] == 6'h1) ? WORD1 : WORD2;
                drv = 1'b0;
                if (cmd[8:6] != 3'b110) bad_command = 1'b1;
            end else if (edges > 9 && edges <= 25) begin
                drv = word[25 - edges];
            end
        end
    end
endmodule : secl_eeprom_model

// File: sim/secl_loader_test.sv
// Self-checking bench for the serial configuration loader.
`timescale 1ns/1ps
module secl_loader_test;
    import secl_pkg::*;
    localparam logic [15:0] W0 = 16'h5a3c; // Arbitrary identifier value.
    localparam logic [15:0] W1 = 16'hc3e1; // Arbitrary identifier value.
    localparam logic [15:0] W2 = 16'hb5e7;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        fitted = 1'b0;
    logic [31:0] reg_rdata;
    logic        mem_select, mem_clock, mem_dout, mem_din;
    logic        load_busy, mem_present, bad_command;
    int          mismatches = 0;
    int          tests_run = 0;
    logic [31:0] offs [4] = '{OFF_SUBSYS_ID, OFF_EPROM_EXT, OFF_LOCAL_WINDOW, OFF_LOCAL_BUS};
    logic [31:0] masks [4] = '{32'hffffffff, 32'h3f, 32'h000f0000, 32'hfc000000};
    logic [31:0] loads [4] = '{{W1, W0}, {26'h0, W2[9:4]}, {12'h0, W2[3:0], 16'h0},
                               {W2[15:10], 26'h0}};
    always #4 clock = ~clock;
    secl_loader #(.HALF(4)) u_secl_loader (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mem_select(mem_select), .mem_clock(mem_clock), .mem_dout(mem_dout),
        .mem_din(mem_din), .load_busy(load_busy), .mem_present(mem_present));
    secl_eeprom_model #(.WORD0(W0), .WORD1(W1), .WORD2(W2)) u_secl_eeprom_model (
        .mem_select(mem_select), .mem_clock(mem_clock), .mem_dout(mem_dout),
        .mem_din(mem_din), .fitted(fitted), .bad_command(bad_command));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
        @(posedge clock);
        #1;
        check("rdata after answer", 32'h0, reg_rdata);
    endtask : rd
    task automatic load(input logic fit);
        int n;
        @(posedge clock);
        fitted <= fit;
        reset <= 1'b1;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        // A write while loading must be refused; with no memory it would otherwise stick.
        wr(OFF_SUBSYS_ID, 32'hffffffff);
        n = 0;
        while (load_busy !== 1'b0 && n < 4000) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (load_busy !== 1'b0) begin
            check("load finished", 32'h0, 32'h1);
            end_sim();
        end
    endtask : load
    initial begin
        load(1'b0);
        check("present flag", 32'h0, {31'h0, mem_present});
        for (int i = 0; i < 4; i++) rd(offs[i], 32'h0, "untouched register");
        rd(OFF_LOAD_STATUS, 32'h4, "status absent");
        load(1'b1);
        check("present flag", 32'h1, {31'h0, mem_present});
        rd(OFF_LOAD_STATUS, 32'h2, "status present");
        for (int i = 0; i < 4; i++) rd(offs[i], loads[i], "loaded register");
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 32'hffffffff);
            rd(offs[i], masks[i], "written register");
        end
        wr(OFF_LOAD_STATUS, 32'hffffffff);
        rd(OFF_LOAD_STATUS, 32'h2, "read-only status");
        wr(32'h1ffa0200, 32'hffffffff);
        rd(32'h1ffa0200, 32'h0, "unmapped read");
        check("bad command", 32'h0, {31'h0, bad_command});
        end_sim();
    end
endmodule : secl_loader_test
